// file: common/rst_wdt_pkg.sv
package rst_wdt_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST_FLAGS = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_ANALOG_CTRL = 8'h02;

    // watchdog control fields
    localparam int BIT_CHG_EN = 4;
    localparam int BIT_WDT_EN = 3;
    localparam int PER_LSB = 0;
    localparam int PER_W = 3;

    // reset flag fields
    localparam int FLAG_POR = 0;
    localparam int FLAG_EXT = 1;
    localparam int FLAG_BROWNOUT = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_SCAN = 4;
    localparam int FLAG_W = 5;

    // analog control fields
    localparam int BIT_BANDGAP_SEL = 0;

    // values after reset
    localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h01;
    localparam logic [PER_W-1:0] PER_RST = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [2:0] CHG_WINDOW_CYC = 3'h4;
    localparam int BROWNOUT_MIN_NS = 2000;
    localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BROWNOUT_CNT_W = 8;
    localparam int TOUT_SHORT_NS = 100;
    localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_MID_US = 4100;
    localparam int TOUT_MID_CYC = (TOUT_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_LONG_US = 65000;
    localparam int TOUT_LONG_CYC = (TOUT_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 23;

    // fuse codes
    localparam logic [1:0] STARTUP_SHORT = 2'h0;
    localparam logic [1:0] STARTUP_MID = 2'h1;
    localparam logic [3:0] EXT_CLOCK_CODE = 4'h0;
    localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;

    // watchdog oscillator cycles for period code zero
    localparam int WDT_BASE_CYC = 16384;
    localparam int WDT_CNT_W = 21;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b100
    } seq_state_type;

endpackage : rst_wdt_pkg

// file: common/wdt_cfg_if.sv
`timescale 1ns/100ps
interface wdt_cfg_if;
    import rst_wdt_pkg::*;
    logic run;
    logic clear;
    logic [PER_W-1:0] period;
    logic expire;

    modport ctrl (output run, output clear, output period, input expire);
    modport counter (input run, input clear, input period, output expire);
endinterface : wdt_cfg_if

// file: src/watchdog_counter.sv
`timescale 1ns/100ps
module watchdog_counter
    import rst_wdt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // watchdog oscillator
    input wire logic wdt_osc,
    // configuration
    wdt_cfg_if.counter cfg
);

    logic osc_s1_ff;
    logic osc_s2_ff;
    logic osc_s3_ff;
    logic [WDT_CNT_W-1:0] cnt_ff;
    logic expire_ff;
    logic tick;

    // last count before expiry: 16K oscillator cycles doubled per code
    function automatic logic [WDT_CNT_W-1:0] wdt_last(input logic [PER_W-1:0] p);
        logic [WDT_CNT_W:0] span;
        span = (WDT_CNT_W+1)'(WDT_BASE_CYC) << p;
        wdt_last = WDT_CNT_W'(span - 1'b1);
    endfunction : wdt_last

    // oscillator is unrelated to clk, so it is synchronised before its edges are counted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else if (ce) begin
            osc_s1_ff <= wdt_osc;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    assign tick = osc_s2_ff & ~osc_s3_ff; // RL12

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            expire_ff <= 1'b0;
        end else if (ce) begin
            expire_ff <= 1'b0;
            if (cfg.clear || !cfg.run) begin
                cnt_ff <= '0; // RL13
            end else if (tick) begin
                if (cnt_ff >= wdt_last(cfg.period)) begin
                    cnt_ff <= '0;
                    expire_ff <= 1'b1; // RL14 RL23
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end

    assign cfg.expire = expire_ff;

endmodule : watchdog_counter

// file: src/reset_and_watchdog_control.sv
`timescale 1ns/100ps
// Contract
// RL1: reset restores registers, release starts vector fetch
// RL2: any source forces reset without a clock; brown-out and watchdog here come from clocked flops
// RL3: stretch reset by fuse-selected delay count
// RL4: five reset sources, any one resets
// RL5: low reset pin resets without clock
// RL6: pin rise starts delay before release
// RL7: supply loss resets at once, rise delays
// RL8: enabled brown-out resets at once, delayed release
// RL9: brown-out ignores dips shorter than minimum
// RL10: scan reset bit holds processor in reset
// RL11: watchdog expiry gives one-cycle pulse, then delay
// RL12: watchdog counts its own oscillator
// RL13: counter cleared by kick, disable, reset
// RL14: eight periods, expiry resets the device
// RL15: always-on fuse selects safety level
// RL16: level one enables freely by writing one
// RL17: level one timed sequence disables or repaces
// RL18: software writes enable one when opening sequence
// RL19: level two enable always set, reads one
// RL20: level two timed sequence changes period only
// RL21: bandgap on for brown-out, comparator, converter
// RL22: change-enable clears itself after four cycles
// RL23: period code selects 16K doubling to 2048K
// RL24: watchdog flag sticky, cleared by power-on, software
// RL25: untimed clear or period write is ignored
// RL26: sources combined, release synchronised to clock
module reset_and_watchdog_control
    import rst_wdt_pkg::*;
#(
    parameter logic [DLY_W-1:0] TOUT_MID = DLY_W'(TOUT_MID_CYC),
    parameter logic [DLY_W-1:0] TOUT_LONG = DLY_W'(TOUT_LONG_CYC)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // reset sources
    input wire logic por_ok,
    input wire logic ext_rst_n,
    input wire logic supply_below,
    input wire logic scan_reset_bit,
    // fuses
    input wire logic always_on_fuse,
    input wire logic [2:0] brownout_level_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic [3:0] clock_select_fuse,
    // watchdog
    input wire logic wdt_osc,
    input wire logic wdt_kick,
    // analog
    input wire logic adc_enable,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    // reset and bandgap outputs
    output logic cpu_reset,
    output logic fetch_start,
    output logic bandgap_on
);

    wdt_cfg_if cfg_bus ();

    seq_state_type state_ff;
    seq_state_type nxt_state;
    logic rel_s1_ff;
    logic rel_s2_ff;
    logic cpu_reset_ff;
    logic nxt_cpu_reset;
    logic fetch_start_ff;
    logic [DLY_W-1:0] dly_cnt_ff;
    logic [DLY_W-1:0] nxt_dly_cnt;
    logic [BROWNOUT_CNT_W-1:0] dip_cnt_ff;
    logic dip_trig_ff;
    logic brownout_en;
    logic wdt_pulse_ff;
    logic wdt_en_ff;
    logic [PER_W-1:0] period_ff;
    logic [2:0] window_ff;
    logic bandgap_sel_ff;
    logic bandgap_on_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic [FLAG_W-1:0] flag_set;
    logic [DATA_W-1:0] rdata_ff;
    logic src_n;
    logic eff_en;
    logic window_open;
    logic ctrl_wr;

    // release delay chosen by fuses; an external clock needs no oscillator settling time
    function automatic logic [DLY_W-1:0] tout_cycles(input logic [1:0] st_fuse, input logic [3:0] cs_fuse);
        if (cs_fuse == EXT_CLOCK_CODE || st_fuse == STARTUP_SHORT) begin
            tout_cycles = DLY_W'(TOUT_SHORT_CYC);
        end else if (st_fuse == STARTUP_MID) begin
            tout_cycles = TOUT_MID;
        end else begin
            tout_cycles = TOUT_LONG;
        end
    endfunction : tout_cycles

    assign brownout_en = brownout_level_fuse != BROWNOUT_OFF_CODE;
    assign eff_en = wdt_en_ff | always_on_fuse; // RL19
    assign window_open = window_ff != 3'h0;
    assign ctrl_wr = wr_en && addr == ADDR_WDT_CTRL;

    // rst_n, power-on, pin and scan pull this low directly with no clock running; brown-out and watchdog arrive from clocked flops
    assign src_n = rst_n & por_ok & ext_rst_n & ~dip_trig_ff & ~scan_reset_bit & ~wdt_pulse_ff; // RL4 RL5 RL7 RL10 RL26

    // release synchroniser: asserted at once, released on clk only
    always_ff @(posedge clk or negedge src_n) begin
        if (!src_n) begin
            rel_s1_ff <= 1'b1; // RL2 RL26
            rel_s2_ff <= 1'b1;
        end else if (ce) begin
            rel_s1_ff <= 1'b0;
            rel_s2_ff <= rel_s1_ff;
        end
    end

    // delay counter sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_dly_cnt = dly_cnt_ff;
        case (state_ff)
            ST_HOLD: begin
                if (!rel_s2_ff) begin
                    nxt_state = ST_DELAY; // RL3 RL6
                    nxt_dly_cnt = tout_cycles(startup_time_fuse, clock_select_fuse);
                end
            end
            ST_DELAY: begin
                if (rel_s2_ff) begin
                    nxt_state = ST_HOLD;
                end else if (dly_cnt_ff <= DLY_W'(1)) begin
                    nxt_state = ST_RUN;
                    nxt_dly_cnt = '0;
                end else begin
                    nxt_dly_cnt = dly_cnt_ff - 1'b1; // RL3
                end
            end
            ST_RUN: begin
                if (rel_s2_ff) begin
                    nxt_state = ST_HOLD;
                end
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
        nxt_cpu_reset = nxt_state != ST_RUN;
    end

    always_ff @(posedge clk or negedge src_n) begin
        if (!src_n) begin
            state_ff <= ST_HOLD;
            dly_cnt_ff <= '0;
            cpu_reset_ff <= 1'b1; // RL2
        end else if (ce) begin
            state_ff <= nxt_state;
            dly_cnt_ff <= nxt_dly_cnt;
            cpu_reset_ff <= nxt_cpu_reset;
        end
    end

    // one pulse as the core leaves reset tells it to fetch from the reset vector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_start_ff <= 1'b0;
        end else if (ce) begin
            fetch_start_ff <= cpu_reset_ff && !nxt_cpu_reset; // RL1
        end
    end

    // brown-out filter: a dip must last the minimum detection time; supply_below
    // already carries the analog hysteresis, so release follows its fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dip_cnt_ff <= '0;
            dip_trig_ff <= 1'b0;
        end else if (ce) begin
            if (!brownout_en || !supply_below) begin
                dip_cnt_ff <= '0;
                dip_trig_ff <= 1'b0; // RL8
            end else if (dip_cnt_ff >= BROWNOUT_CNT_W'(BROWNOUT_MIN_CYC - 1)) begin
                dip_trig_ff <= 1'b1; // RL8 RL9
            end else begin
                dip_cnt_ff <= dip_cnt_ff + 1'b1; // RL9
            end
        end
    end

    // watchdog expiry pulse; it feeds the combined source, so it cannot be cleared by the reset it causes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_pulse_ff <= 1'b0;
        end else if (ce) begin
            wdt_pulse_ff <= cfg_bus.expire & ~wdt_pulse_ff; // RL11 RL14
        end
    end

    assign cfg_bus.run = eff_en & ~cpu_reset_ff;
    assign cfg_bus.clear = wdt_kick | ~eff_en | cpu_reset_ff; // RL13
    assign cfg_bus.period = period_ff;

    watchdog_counter watchdog_counter_i (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .wdt_osc(wdt_osc),
        .cfg(cfg_bus.counter)
    );

    // watchdog configuration and timed change window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_en_ff <= 1'b0;
            period_ff <= PER_RST;
            window_ff <= 3'h0;
        end else if (ce) begin
            if (cpu_reset_ff) begin
                wdt_en_ff <= always_on_fuse; // RL1 RL15
                period_ff <= PER_RST;
                window_ff <= 3'h0;
            end else if (ctrl_wr && window_open && !wdata[BIT_CHG_EN]) begin
                period_ff <= wdata[PER_LSB +: PER_W]; // RL17 RL20
                wdt_en_ff <= always_on_fuse | wdata[BIT_WDT_EN]; // RL17 RL20
                window_ff <= 3'h0;
            end else begin
                if (ctrl_wr && wdata[BIT_WDT_EN]) begin
                    wdt_en_ff <= 1'b1; // RL16 RL25
                end
                if (ctrl_wr && wdata[BIT_CHG_EN] && wdata[BIT_WDT_EN]) begin
                    window_ff <= CHG_WINDOW_CYC; // RL17 RL18 RL20
                end else if (window_open) begin
                    window_ff <= window_ff - 3'h1; // RL22
                end
            end
        end
    end

    // analog control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bandgap_sel_ff <= 1'b0;
            bandgap_on_ff <= 1'b0;
        end else if (ce) begin
            if (cpu_reset_ff) begin
                bandgap_sel_ff <= 1'b0; // RL1
            end else if (wr_en && addr == ADDR_ANALOG_CTRL) begin
                bandgap_sel_ff <= wdata[BIT_BANDGAP_SEL];
            end
            bandgap_on_ff <= brownout_en | bandgap_sel_ff | adc_enable; // RL21
        end
    end

    // reset cause flags survive the internal reset; a new cause beats a software clear
    always_comb begin
        flag_set = '0;
        flag_set[FLAG_POR] = ~por_ok;
        flag_set[FLAG_EXT] = ~ext_rst_n;
        flag_set[FLAG_BROWNOUT] = dip_trig_ff;
        flag_set[FLAG_WDT] = wdt_pulse_ff;
        flag_set[FLAG_SCAN] = scan_reset_bit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= FLAGS_RST;
        end else if (ce) begin
            if (flag_set[FLAG_POR]) begin
                flags_ff <= FLAGS_RST; // RL24
            end else if (wr_en && addr == ADDR_RST_FLAGS) begin
                flags_ff <= (flags_ff & wdata[FLAG_W-1:0]) | flag_set; // RL24
            end else begin
                flags_ff <= flags_ff | flag_set; // RL24
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= RDATA_RST;
        end else if (ce) begin
            rdata_ff <= RDATA_RST;
            if (rd_en) begin
                case (addr)
                    ADDR_WDT_CTRL: begin
                        rdata_ff[BIT_CHG_EN] <= window_open;
                        rdata_ff[BIT_WDT_EN] <= eff_en; // RL19
                        rdata_ff[PER_LSB +: PER_W] <= period_ff;
                    end
                    ADDR_RST_FLAGS: begin
                        rdata_ff[FLAG_W-1:0] <= flags_ff;
                    end
                    ADDR_ANALOG_CTRL: begin
                        rdata_ff[BIT_BANDGAP_SEL] <= bandgap_sel_ff;
                    end
                    default: begin
                        rdata_ff <= RDATA_RST;
                    end
                endcase
            end
        end
    end

    assign rdata = rdata_ff;
    assign cpu_reset = cpu_reset_ff;
    assign fetch_start = fetch_start_ff;
    assign bandgap_on = bandgap_on_ff;

endmodule : reset_and_watchdog_control

// file: sim/rst_wdt_checker.sv
`timescale 1ns/100ps
module rst_wdt_checker
    import rst_wdt_pkg::*;
#(
    parameter logic [DLY_W-1:0] TOUT_MID = DLY_W'(TOUT_MID_CYC),
    parameter logic [DLY_W-1:0] TOUT_LONG = DLY_W'(TOUT_LONG_CYC)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sources, fuses and converter enable
    input wire logic por_ok,
    input wire logic ext_rst_n,
    input wire logic supply_below,
    input wire logic scan_reset_bit,
    input wire logic always_on_fuse,
    input wire logic [2:0] brownout_level_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic [3:0] clock_select_fuse,
    input wire logic adc_enable,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rdata,
    // outputs
    input wire logic cpu_reset,
    input wire logic fetch_start,
    input wire logic bandgap_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic opening;
    int dly;
    int hold_ff;
    logic [3:0] open_ff;
    assign opening = wr_en && addr == ADDR_WDT_CTRL && wdata[BIT_CHG_EN] && wdata[BIT_WDT_EN] && !cpu_reset;
    assign dly = (startup_time_fuse == STARTUP_SHORT || clock_select_fuse == EXT_CLOCK_CODE) ? TOUT_SHORT_CYC :
        (startup_time_fuse == STARTUP_MID) ? int'(TOUT_MID) : int'(TOUT_LONG);
    // brown-out level counts as busy so the hold count stays a lower bound
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) hold_ff <= 0;
        else if (!por_ok || !ext_rst_n || scan_reset_bit || supply_below || !cpu_reset) hold_ff <= 0;
        else hold_ff <= hold_ff + 1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) open_ff <= 4'hf;
        else if (opening) open_ff <= 4'h0;
        else if (open_ff != 4'hf) open_ff <= open_ff + 4'h1;
    end
    src_forces_reset_a: assert property (!por_ok || !ext_rst_n || scan_reset_bit |-> cpu_reset)
        else $error("source active but core not in reset");
    fetch_on_release_a: assert property ($fell(cpu_reset) |-> fetch_start)
        else $error("no fetch start at release");
    fetch_cause_a: assert property (fetch_start |-> $fell(cpu_reset) ##1 !fetch_start)
        else $error("stray or long fetch start");
    release_min_a: assert property ($fell(cpu_reset) |-> hold_ff >= dly)
        else $error("reset released before delay");
    release_max_a: assert property (cpu_reset |-> hold_ff <= dly + 10)
        else $error("reset held past delay");
    level2_enable_a: assert property ($past(rd_en && addr == ADDR_WDT_CTRL) && always_on_fuse
        |-> rdata[BIT_WDT_EN])
        else $error("enable read zero in level two");
    window_open_a: assert property (opening ##2 (rd_en && addr == ADDR_WDT_CTRL) |=> rdata[BIT_CHG_EN])
        else $error("window not open after opening write");
    window_close_a: assert property ($past(rd_en && addr == ADDR_WDT_CTRL) && open_ff > 4'h7
        |-> !rdata[BIT_CHG_EN])
        else $error("change enable not cleared");
    bandgap_need_a: assert property (brownout_level_fuse != BROWNOUT_OFF_CODE || adc_enable |=> bandgap_on)
        else $error("bandgap off while needed");
    scan_hold_a: assert property (scan_reset_bit [*2] |-> cpu_reset && !fetch_start)
        else $error("scan reset not holding core");
    release_c: cover property ($fell(cpu_reset));
    opening_c: cover property (opening);
    dog_c: cover property ($rose(cpu_reset) && por_ok && ext_rst_n && !scan_reset_bit && !supply_below);
endmodule : rst_wdt_checker

bind reset_and_watchdog_control rst_wdt_checker #(.TOUT_MID(TOUT_MID), .TOUT_LONG(TOUT_LONG)) rst_wdt_checker_i (
    .clk(clk), .rst_n(rst_n), .por_ok(por_ok), .ext_rst_n(ext_rst_n), .supply_below(supply_below),
    .scan_reset_bit(scan_reset_bit), .always_on_fuse(always_on_fuse), .brownout_level_fuse(brownout_level_fuse),
    .startup_time_fuse(startup_time_fuse), .clock_select_fuse(clock_select_fuse), .adc_enable(adc_enable),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_reset(cpu_reset),
    .fetch_start(fetch_start), .bandgap_on(bandgap_on));

// file: sim/reset_and_watchdog_control_tb_top.sv
`timescale 1ns/100ps
module reset_and_watchdog_control_tb_top;
    import rst_wdt_pkg::*;
    localparam int N = TOUT_SHORT_CYC;
    localparam int MID = 20;
    localparam int LONG = 40;
    logic clk, rst_n, ce, por_ok, ext_rst_n, supply_below, scan_reset_bit, always_on_fuse;
    logic wdt_osc, wdt_kick, adc_enable, wr_en, rd_en, cpu_reset, fetch_start, bandgap_on;
    logic [2:0] brownout_level_fuse;
    logic [1:0] startup_time_fuse;
    logic [3:0] clock_select_fuse;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    int err_count, total_checks, seed, i, e, w;
    int cycles = 0;
    int dly_tab[5] = '{N, MID, LONG, LONG, N};
    logic [1:0] sut_tab[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};

    reset_and_watchdog_control #(.TOUT_MID(DLY_W'(MID)), .TOUT_LONG(DLY_W'(LONG))) reset_and_watchdog_control_i (
        .clk(clk), .rst_n(rst_n), .ce(ce), .por_ok(por_ok), .ext_rst_n(ext_rst_n), .supply_below(supply_below),
        .scan_reset_bit(scan_reset_bit), .always_on_fuse(always_on_fuse), .brownout_level_fuse(brownout_level_fuse),
        .startup_time_fuse(startup_time_fuse), .clock_select_fuse(clock_select_fuse), .wdt_osc(wdt_osc),
        .wdt_kick(wdt_kick), .adc_enable(adc_enable), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .cpu_reset(cpu_reset), .fetch_start(fetch_start), .bandgap_on(bandgap_on));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // the watchdog run of about 66000 cycles dominates the budget
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 90000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] m = 8'hff);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata & m;
        chk("rdata", d, x);
    endtask : rdc

    // count edges until the core leaves reset; a little slack for synchroniser phase
    task automatic rel(input int n);
        e = 0;
        while (cpu_reset !== 1'b0 && e < n + 30) begin
            @(posedge clk);
            #1 e++;
        end
        chk("release delay", e >= n + 2 && e <= n + 5, 1);
        chk("fetch_start", fetch_start, 1);
    endtask : rel

    task automatic hard_reset(input int n, input logic lvl, input logic [1:0] s, input logic [3:0] c);
        @(posedge clk);
        rst_n <= 1'b0;
        always_on_fuse <= lvl;
        startup_time_fuse <= s;
        clock_select_fuse <= c;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rel(n);
    endtask : hard_reset

    task automatic src(input int k, input logic [DATA_W-1:0] f);
        @(posedge clk);
        por_ok <= k != 0;
        ext_rst_n <= k != 1;
        scan_reset_bit <= k == 2;
        #1 chk("async reset", cpu_reset, 1);
        repeat (3) @(posedge clk);
        por_ok <= 1'b1;
        ext_rst_n <= 1'b1;
        scan_reset_bit <= 1'b0;
        rel(N);
        rdc(ADDR_RST_FLAGS, f);
    endtask : src

    task automatic dip(input logic [2:0] fuse, input int len, input logic exp);
        @(posedge clk);
        brownout_level_fuse <= fuse;
        supply_below <= 1'b1;
        repeat (len) @(posedge clk);
        supply_below <= 1'b0;
        #1 chk("brown-out reset", cpu_reset, exp);
    endtask : dip

    initial begin
        seed = 74;
        rst_n = 1'b0;
        ce = 1'b1;
        por_ok = 1'b1;
        ext_rst_n = 1'b1;
        supply_below = 1'b0;
        scan_reset_bit = 1'b0;
        always_on_fuse = 1'b0;
        brownout_level_fuse = BROWNOUT_OFF_CODE;
        startup_time_fuse = STARTUP_SHORT;
        clock_select_fuse = 4'h1;
        wdt_osc = 1'b0;
        wdt_kick = 1'b0;
        adc_enable = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        for (i = 0; i < 5; i++) begin
            hard_reset(dly_tab[i], 1'b0, sut_tab[i], i == 4 ? EXT_CLOCK_CODE : 4'h1);
        end
        rdc(ADDR_RST_FLAGS, 8'h01);
        wr(ADDR_RST_FLAGS, 8'h00);
        rdc(ADDR_RST_FLAGS, 8'h00);
        src(1, 8'h02);
        src(2, 8'h12);
        src(0, 8'h01);
        dip(3'h0, 50, 1'b0);
        dip(3'h0, 110, 1'b1);
        rel(N + 1);
        rdc(ADDR_RST_FLAGS, 8'h05);
        dip(BROWNOUT_OFF_CODE, 110, 1'b0);
        rdc(ADDR_WDT_CTRL, 8'h00);
        wr(ADDR_WDT_CTRL, 8'h08);
        rdc(ADDR_WDT_CTRL, 8'h08);
        wr(ADDR_WDT_CTRL, 8'h07);
        rdc(ADDR_WDT_CTRL, 8'h08);
        wr(ADDR_WDT_CTRL, 8'h18);
        wr(ADDR_WDT_CTRL, 8'h05);
        rdc(ADDR_WDT_CTRL, 8'h05);
        wr(ADDR_WDT_CTRL, 8'h0d);
        wr(ADDR_WDT_CTRL, 8'h1d);
        rdc(ADDR_WDT_CTRL, 8'h1d);
        repeat (6) @(posedge clk);
        wr(ADDR_WDT_CTRL, 8'h00);
        rdc(ADDR_WDT_CTRL, 8'h0d);
        for (i = 0; i < 6; i++) begin
            d = DATA_W'($random(seed));
            wr(d | 8'h03, d);
            rdc(d | 8'h03, 8'h00);
            @(posedge clk);
            adc_enable <= d[5];
            wr(ADDR_ANALOG_CTRL, d);
            rdc(ADDR_ANALOG_CTRL, {7'h00, d[0]}, 8'h01);
            chk("bandgap", bandgap_on, d[0] | d[5]);
        end
        wr(ADDR_RST_FLAGS, 8'h00);
        wr(ADDR_WDT_CTRL, 8'h18);
        wr(ADDR_WDT_CTRL, 8'h08);
        @(posedge clk);
        wdt_kick <= 1'b1;
        @(posedge clk);
        wdt_kick <= 1'b0;
        w = 0;
        while (cpu_reset === 1'b0 && w < 16400) begin
            repeat (2) @(posedge clk);
            wdt_osc <= ~wdt_osc;
            w += wdt_osc ? 0 : 1;
        end
        chk("watchdog expiry", w >= 16384 && w <= 16386, 1);
        rel(N);
        rdc(ADDR_RST_FLAGS, 8'h08);
        rdc(ADDR_WDT_CTRL, 8'h00);
        hard_reset(N, 1'b1, STARTUP_SHORT, 4'h1);
        rdc(ADDR_WDT_CTRL, 8'h08);
        wr(ADDR_WDT_CTRL, 8'h00);
        rdc(ADDR_WDT_CTRL, 8'h08);
        wr(ADDR_WDT_CTRL, 8'h18);
        // a frozen block must hold the window open; unfrozen it would have closed by now
        @(posedge clk);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wr(ADDR_WDT_CTRL, 8'h03);
        rdc(ADDR_WDT_CTRL, 8'h0b);
        stop_test();
    end
endmodule : reset_and_watchdog_control_tb_top
